/* inc/wt_pkg.sv */
`default_nettype none
package wt_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] WT_ADDR_MASK  = 8'h04;
  localparam logic [7:0] WT_ADDR_FLAGS = 8'h05;
  localparam logic [7:0] WT_ADDR_MODE  = 8'h06;
  localparam logic [7:0] WT_ADDR_EDGE  = 8'h0c;
  localparam logic [7:0] WT_ADDR_PADIE = 8'h0d;
  localparam logic [7:0] WT_ADDR_PBDIE = 8'h0e;
  localparam logic [7:0] WT_ADDR_PSEL  = 8'h0f;
  localparam logic [7:0] WT_ADDR_CNTL  = 8'h20;
  localparam logic [7:0] WT_ADDR_CNTH  = 8'h21;
  // ==========================================================
  // reset values
  localparam logic [7:0] WT_RST_ZERO  = 8'h00;
  localparam logic [7:0] WT_RST_PADIE = 8'hf9;
  localparam logic [7:0] WT_RST_PBDIE = 8'hff;
  // ==========================================================
  // field positions
  localparam int WT_MODE_SRC_LSB = 5;
  localparam int WT_MODE_DIV_LSB = 3;
  localparam int WT_MODE_BIT_LSB = 0;
  localparam int WT_EDGE_TMR     = 4;
  localparam int WT_EDGE_F1_LSB  = 2;
  localparam int WT_EDGE_F0_LSB  = 0;
  localparam int WT_PADIE_PIN0   = 0;
  localparam int WT_PADIE_PIN4   = 4;
  localparam int WT_PBDIE_PIN0   = 0;
  localparam int WT_PBDIE_PIN5   = 5;
  localparam int WT_PSEL_F0_PB5  = 0;
  localparam int WT_PSEL_F1_PA4  = 1;
  localparam int WT_FLAG_PIN0    = 0;
  localparam int WT_FLAG_PIN1    = 1;
  localparam int WT_FLAG_TIMER   = 2;
  localparam int WT_FLAG_CONV    = 3;
  localparam int WT_FLAG_CMP     = 4;
  localparam int WT_FLAG_PWM0    = 5;
  localparam int WT_FLAG_TMR2    = 6;
  localparam int WT_FLAG_TMR3    = 7;
  localparam int WT_EVT_BIT_BASE = 8;
  // ==========================================================
  // codes
  typedef enum logic [2:0] {
    WT_SRC_OFF  = 3'b000,
    WT_SRC_SYS  = 3'b001,
    WT_SRC_RSV  = 3'b010,
    WT_SRC_PA4  = 3'b011,
    WT_SRC_FAST = 3'b100,
    WT_SRC_XTAL = 3'b101,
    WT_SRC_SLOW = 3'b110,
    WT_SRC_PA0  = 3'b111
  } wt_src_t;
  localparam logic [1:0] WT_PEDGE_BOTH = 2'h0;
  localparam logic [1:0] WT_PEDGE_RISE = 2'h1;
  localparam logic [1:0] WT_PEDGE_FALL = 2'h2;
  localparam logic [5:0] WT_DIV1_MASK  = 6'h00;
  localparam logic [5:0] WT_DIV4_MASK  = 6'h03;
  localparam logic [5:0] WT_DIV16_MASK = 6'h0f;
  localparam logic [5:0] WT_DIV64_MASK = 6'h3f;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wt_bus_req_t;
  typedef struct packed {
    logic fast_tick;
    logic xtal_tick;
    logic slow_tick;
  } wt_osc_t;
  typedef struct packed {
    logic conv;
    logic tmr2;
    logic tmr3;
    logic pwm0;
    logic pwm1;
    logic pwm2;
    logic cmp;
  } wt_periph_t;
  typedef struct packed {
    logic pa0;
    logic pa4;
    logic pb0;
    logic pb5;
  } wt_pins_t;
endpackage
`default_nettype wire

/* logic/wt_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module wt_timer #(
  parameter bit FLAG7_USE_PWM = 1'b0,
  parameter bit FLAG4_USE_PWM = 1'b0
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            reset_n,
  // register port
  input  wire wt_pkg::wt_bus_req_t bus,
  output var  logic [7:0]      rdata,
  // clock source ticks
  input  wire wt_pkg::wt_osc_t osc,
  // peripheral requests
  input  wire wt_pkg::wt_periph_t periph,
  // pins
  input  wire wt_pkg::wt_pins_t pins,
  // interrupt
  output var  logic            irq
);
  import wt_pkg::*;

  // ==========================================================
  // reset release
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ==========================================================
  // registers
  logic [7:0]  mask;
  logic [7:0]  flags;
  logic [7:0]  mode;
  logic [7:0]  edge_cfg;
  logic [7:0]  padie;
  logic [7:0]  pbdie;
  logic [7:0]  psel;
  logic [15:0] count;

  logic wr_mask;
  logic wr_flags;
  logic wr_mode;
  logic wr_edge;
  logic wr_padie;
  logic wr_pbdie;
  logic wr_psel;
  assign wr_mask  = bus.wr && (bus.addr == WT_ADDR_MASK);
  assign wr_flags = bus.wr && (bus.addr == WT_ADDR_FLAGS);
  assign wr_mode  = bus.wr && (bus.addr == WT_ADDR_MODE);
  assign wr_edge  = bus.wr && (bus.addr == WT_ADDR_EDGE);
  assign wr_padie = bus.wr && (bus.addr == WT_ADDR_PADIE);
  assign wr_pbdie = bus.wr && (bus.addr == WT_ADDR_PBDIE);
  assign wr_psel  = bus.wr && (bus.addr == WT_ADDR_PSEL);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask     <= WT_RST_ZERO;
      mode     <= WT_RST_ZERO;
      edge_cfg <= WT_RST_ZERO;
      padie    <= WT_RST_PADIE;
      pbdie    <= WT_RST_PBDIE;
      psel     <= WT_RST_ZERO;
    end else begin
      if (wr_mask) begin
        mask <= bus.wdata;
      end
      if (wr_mode) begin
        mode <= bus.wdata;
      end
      if (wr_edge) begin
        edge_cfg <= bus.wdata;
      end
      if (wr_padie) begin
        padie <= bus.wdata;
      end
      if (wr_pbdie) begin
        pbdie <= bus.wdata;
      end
      if (wr_psel) begin
        psel <= bus.wdata;
      end
    end
  end

  // ==========================================================
  // pin edges
  wt_pins_t pins_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins;
    end
  end

  logic pa0_en;
  logic pa4_en;
  logic pb0_en;
  logic pb5_en;
  assign pa0_en = padie[WT_PADIE_PIN0];
  assign pa4_en = padie[WT_PADIE_PIN4];
  assign pb0_en = pbdie[WT_PBDIE_PIN0];
  assign pb5_en = pbdie[WT_PBDIE_PIN5];

  logic pa0_fall;
  logic pa4_fall;
  assign pa0_fall = pa0_en && pins_q.pa0 && !pins.pa0;
  assign pa4_fall = pa4_en && pins_q.pa4 && !pins.pa4;

  // ==========================================================
  // clock source select
  wt_src_t src;
  logic    src_tick;
  assign src = wt_src_t'(mode[WT_MODE_SRC_LSB +: 3]);

  always_comb begin
    unique case (src)
      WT_SRC_OFF:  src_tick = 1'b0;
      WT_SRC_SYS:  src_tick = 1'b1;
      WT_SRC_RSV:  src_tick = 1'b0;
      WT_SRC_PA4:  src_tick = pa4_fall;
      WT_SRC_FAST: src_tick = osc.fast_tick;
      WT_SRC_XTAL: src_tick = osc.xtal_tick;
      WT_SRC_SLOW: src_tick = osc.slow_tick;
      WT_SRC_PA0:  src_tick = pa0_fall;
    endcase
  end

  // ==========================================================
  // pre-divider
  logic [5:0] div_mask;
  logic [5:0] pre_cnt;
  logic       step;

  always_comb begin
    unique case (mode[WT_MODE_DIV_LSB +: 2])
      2'h0: div_mask = WT_DIV1_MASK;
      2'h1: div_mask = WT_DIV4_MASK;
      2'h2: div_mask = WT_DIV16_MASK;
      2'h3: div_mask = WT_DIV64_MASK;
    endcase
  end

  assign step = src_tick && ((pre_cnt & div_mask) == div_mask);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 6'h00;
    end else if (src_tick) begin
      pre_cnt <= step ? 6'h00 : pre_cnt + 6'h01;
    end
  end

  // ==========================================================
  // counter
  logic [15:0] next_count;
  assign next_count = count + 16'h0001;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
    end else if (step) begin
      count <= next_count;
    end
  end

  // ==========================================================
  // timer event
  logic [3:0] evt_idx;
  logic       old_bit;
  logic       new_bit;
  logic       tmr_evt;
  assign evt_idx = 4'(WT_EVT_BIT_BASE) +
                   {1'b0, mode[WT_MODE_BIT_LSB +: 3]};
  assign old_bit = count[evt_idx];
  assign new_bit = next_count[evt_idx];
  assign tmr_evt = step && (edge_cfg[WT_EDGE_TMR] ?
                   (old_bit && !new_bit) :
                   (!old_bit && new_bit));

  // ==========================================================
  // pin request edges
  function automatic logic pin_hit(input logic [1:0] sel,
                                   input logic       en,
                                   input logic       prev,
                                   input logic       cur);
    logic rise;
    logic fall;
    rise = en && !prev && cur;
    fall = en && prev && !cur;
    unique case (sel)
      WT_PEDGE_BOTH: pin_hit = rise || fall;
      WT_PEDGE_RISE: pin_hit = rise;
      WT_PEDGE_FALL: pin_hit = fall;
      default:       pin_hit = 1'b0;
    endcase
  endfunction

  logic f0_hit;
  logic f1_hit;
  always_comb begin
    if (psel[WT_PSEL_F0_PB5]) begin
      f0_hit = pin_hit(edge_cfg[WT_EDGE_F0_LSB +: 2], pb5_en,
                       pins_q.pb5, pins.pb5);
    end else begin
      f0_hit = pin_hit(edge_cfg[WT_EDGE_F0_LSB +: 2], pa0_en,
                       pins_q.pa0, pins.pa0);
    end
    if (psel[WT_PSEL_F1_PA4]) begin
      f1_hit = pin_hit(edge_cfg[WT_EDGE_F1_LSB +: 2], pa4_en,
                       pins_q.pa4, pins.pa4);
    end else begin
      f1_hit = pin_hit(edge_cfg[WT_EDGE_F1_LSB +: 2], pb0_en,
                       pins_q.pb0, pins.pb0);
    end
  end

  // ==========================================================
  // request flags
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] next_flags;

  always_comb begin
    set_vec = 8'h00;
    set_vec[WT_FLAG_PIN0]  = f0_hit;
    set_vec[WT_FLAG_PIN1]  = f1_hit;
    set_vec[WT_FLAG_TIMER] = tmr_evt;
    set_vec[WT_FLAG_CONV]  = periph.conv;
    set_vec[WT_FLAG_CMP]   = FLAG4_USE_PWM ?
                             periph.pwm1 : periph.cmp;
    set_vec[WT_FLAG_PWM0]  = periph.pwm0;
    set_vec[WT_FLAG_TMR2]  = periph.tmr2;
    set_vec[WT_FLAG_TMR3]  = FLAG7_USE_PWM ?
                             periph.pwm2 : periph.tmr3;
  end

  assign clr_vec    = wr_flags ? bus.wdata : 8'h00;
  assign next_flags = (flags & ~clr_vec) | set_vec;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= WT_RST_ZERO;
    end else begin
      flags <= next_flags;
    end
  end

  // ==========================================================
  // interrupt output
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & mask);
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        WT_ADDR_MASK:  rdata <= mask;
        WT_ADDR_FLAGS: rdata <= flags;
        WT_ADDR_MODE:  rdata <= mode;
        WT_ADDR_PSEL:  rdata <= psel;
        WT_ADDR_CNTL:  rdata <= count[7:0];
        WT_ADDR_CNTH:  rdata <= count[15:8];
        default:       rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* sim/wt_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wt_core_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // interrupt line and tally
  input  wire logic       irq,
  output var  logic [7:0] irq_count
);
  logic irq_seen;
  // ==========================================================
  // count interrupts taken by the core
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_seen  <= 1'b0;
      irq_count <= 8'h00;
    end else begin
      irq_seen <= irq;
      if (irq && !irq_seen) begin
        irq_count <= irq_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/wt_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module wt_monitor (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               reset_n,
  // watched ports
  input wire wt_pkg::wt_bus_req_t bus,
  input wire logic [7:0]         rdata,
  input wire wt_pkg::wt_osc_t    osc,
  input wire wt_pkg::wt_periph_t periph,
  input wire wt_pkg::wt_pins_t   pins,
  input wire logic               irq
);
  import wt_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic rd_flags = bus.rd && (bus.addr == WT_ADDR_FLAGS);
  // ==========================================================
  // flags set by requests
  conv_flag_a: assert property (
    periph.conv ##1 rd_flags |=> rdata[WT_FLAG_CONV])
    else $error("flag 3 not set");
  tmr2_flag_a: assert property (
    periph.tmr2 ##1 rd_flags |=> rdata[WT_FLAG_TMR2])
    else $error("flag 6 not set");
  pwm0_flag_a: assert property (
    periph.pwm0 ##1 rd_flags |=> rdata[WT_FLAG_PWM0])
    else $error("flag 5 not set");
  tmr3_flag_a: assert property (
    periph.tmr3 ##1 rd_flags |=> rdata[WT_FLAG_TMR3])
    else $error("flag 7 not set");
  cmp_flag_a: assert property (
    periph.cmp ##1 rd_flags |=> rdata[WT_FLAG_CMP])
    else $error("flag 4 not set");
  // ==========================================================
  // clearing and masking
  flag_clear_a: assert property (
    bus.wr && bus.addr == WT_ADDR_FLAGS && bus.wdata == 8'hff &&
    periph == '0 ##1 rd_flags && periph == '0 |=> rdata[7:3] == 5'h00)
    else $error("flags not cleared");
  mask_off_a: assert property (
    bus.wr && bus.addr == WT_ADDR_MASK && bus.wdata == 8'h00 |=> ##1 !irq)
    else $error("irq despite zero mask");
  mask_on_a: assert property (
    bus.wr && bus.addr == WT_ADDR_MASK && bus.wdata == 8'hff ##1 rd_flags
    ##1 rdata != 8'h00 |-> ##1 irq)
    else $error("irq missing");
endmodule
bind wt_timer wt_monitor u_wt_monitor (.ref_clk(ref_clk), .reset_n(reset_n),
  .bus(bus), .rdata(rdata), .osc(osc), .periph(periph), .pins(pins),
  .irq(irq));
`default_nettype wire

/* sim/test_wt_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_wt_timer;
  import wt_pkg::*;
  logic        ref_clk;
  logic        reset_n;
  wt_bus_req_t bus;
  wt_osc_t     osc;
  wt_periph_t  periph;
  wt_pins_t    pins;
  logic [7:0]  rdata;
  logic        irq;
  logic [7:0]  irq_count;
  int          failures = 0;
  int          checked = 0;
  logic [7:0]  exp_flag [7] = '{8'h08, 8'h40, 8'h80, 8'h20, 8'h00, 8'h00,
                               8'h10};
  wt_timer u_wt_timer (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus),
    .rdata(rdata), .osc(osc), .periph(periph), .pins(pins), .irq(irq));
  wt_core_model u_wt_core_model (.ref_clk(ref_clk), .reset_n(reset_n),
    .irq(irq), .irq_count(irq_count));
  // ==========================================================
  // clock, access tasks
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{a, d, 1'b1, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    periph <= '0;
    bus    <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic put(input logic [3:0] p);
    @(posedge ref_clk);
    bus  <= '0;
    pins <= p;
  endtask
  task automatic ticks(input logic [2:0] t, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      bus <= '0;
      osc <= t;
    end
    @(posedge ref_clk);
    osc <= '0;
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    pins    <= '0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    reset_n = 1'b0;
    bus     = '0;
    osc     = '0;
    periph  = '0;
    pins    = '0;
    do_reset();
    rd(WT_ADDR_MASK, 8'h00);
    rd(WT_ADDR_MODE, 8'h00);
    rd(WT_ADDR_EDGE, 8'h00);
    rd(8'h07, 8'h00);
    $display("test defaults done");
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      bus    <= '0;
      periph <= wt_periph_t'(7'h40 >> i);
      rd(WT_ADDR_FLAGS, exp_flag[i]);
      wr(WT_ADDR_FLAGS, 8'hff);
      rd(WT_ADDR_FLAGS, 8'h00);
    end
    @(posedge ref_clk);
    periph.conv <= 1'b1;
    bus         <= '{WT_ADDR_FLAGS, 8'hff, 1'b1, 1'b0};
    rd(WT_ADDR_FLAGS, 8'h08);
    $display("test flags done");
    wr(WT_ADDR_MASK, 8'hff);
    rd(WT_ADDR_FLAGS, 8'h08);
    chk({7'h00, irq}, 8'h01);
    wr(WT_ADDR_MASK, 8'h00);
    put(pins);
    @(posedge ref_clk);
    #1;
    chk({7'h00, irq}, 8'h00);
    wr(WT_ADDR_MASK, 8'h08);
    wr(WT_ADDR_FLAGS, 8'hff);
    rd(WT_ADDR_FLAGS, 8'h00);
    chk({7'h00, irq}, 8'h00);
    chk(irq_count, 8'h02);
    $display("test interrupt done");
    put(4'b1000);
    rd(WT_ADDR_FLAGS, 8'h01);
    wr(WT_ADDR_FLAGS, 8'hff);
    wr(WT_ADDR_EDGE, 8'h01);
    put(4'b0000);
    rd(WT_ADDR_FLAGS, 8'h00);
    wr(WT_ADDR_PSEL, 8'h01);
    put(4'b0001);
    rd(WT_ADDR_FLAGS, 8'h01);
    wr(WT_ADDR_FLAGS, 8'hff);
    wr(WT_ADDR_PSEL, 8'h03);
    put(4'b0101);
    rd(WT_ADDR_FLAGS, 8'h02);
    wr(WT_ADDR_FLAGS, 8'hff);
    wr(WT_ADDR_PADIE, 8'h00);
    put(4'b0001);
    rd(WT_ADDR_FLAGS, 8'h00);
    $display("test pins done");
    wr(WT_ADDR_MODE, 8'h28);
    put(4'b0001);
    repeat (1000) @(posedge ref_clk);
    rd(WT_ADDR_FLAGS, 8'h00);
    repeat (40) @(posedge ref_clk);
    rd(WT_ADDR_FLAGS, 8'h04);
    wr(WT_ADDR_FLAGS, 8'hff);
    wr(WT_ADDR_EDGE, 8'h10);
    rd(WT_ADDR_FLAGS, 8'h00);
    repeat (1040) @(posedge ref_clk);
    rd(WT_ADDR_FLAGS, 8'h04);
    $display("test timer done");
    do_reset();
    put(4'b0100);
    put(4'b0000);
    rd(WT_ADDR_CNTL, 8'h00);
    wr(WT_ADDR_MODE, 8'h60);
    for (int n = 0; n < 5; n++) begin
      if (n == 3) begin
        rd(WT_ADDR_CNTL, 8'h03);
        wr(WT_ADDR_PADIE, 8'he9);
      end
      put(4'b0100);
      put(4'b0000);
    end
    rd(WT_ADDR_CNTL, 8'h03);
    $display("test pin count done");
    do_reset();
    wr(WT_ADDR_MODE, 8'h90);
    ticks(3'b100, 32);
    rd(WT_ADDR_CNTL, 8'h02);
    wr(WT_ADDR_MODE, 8'hb8);
    ticks(3'b001, 64);
    ticks(3'b010, 64);
    rd(WT_ADDR_CNTL, 8'h03);
    wr(WT_ADDR_MODE, 8'hc0);
    ticks(3'b001, 5);
    wr(WT_ADDR_MODE, 8'h40);
    ticks(3'b111, 8);
    rd(WT_ADDR_CNTL, 8'h08);
    wr(WT_ADDR_MODE, 8'he0);
    put(4'b1000);
    put(4'b0000);
    rd(WT_ADDR_CNTL, 8'h09);
    wr(WT_ADDR_FLAGS, 8'hff);
    wr(WT_ADDR_MODE, 8'h21);
    put(4'b0000);
    repeat (300) @(posedge ref_clk);
    rd(WT_ADDR_FLAGS, 8'h00);
    repeat (300) @(posedge ref_clk);
    rd(WT_ADDR_FLAGS, 8'h04);
    wr(WT_ADDR_MODE, 8'h00);
    rd(WT_ADDR_CNTH, 8'h02);
    $display("test sources done");
    wr(WT_ADDR_FLAGS, 8'hff);
    wr(WT_ADDR_EDGE, 8'h0e);
    put(4'b1010);
    put(4'b0000);
    rd(WT_ADDR_FLAGS, 8'h01);
    wr(WT_ADDR_EDGE, 8'h04);
    put(4'b0010);
    rd(WT_ADDR_FLAGS, 8'h03);
    $display("test edge codes done");
    give_verdict();
  end
endmodule
`default_nettype wire
